// ==== verilog/gas_debounce.sv ====
// shared package and the level debouncer of the gas alarm controller
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// package
// ----------------------------------------------------------------------
package gas_pkg;
    typedef enum logic [2:0] {
        ST_WARMUP,
        ST_NORMAL,
        ST_WARNING,
        ST_ALARM,
        ST_ERROR
    } gas_state_t;

    typedef struct packed {
        logic [7:0] alarm_thr;     // alarm level, reading steps
        logic [7:0] warn_pct;      // warning level, percent of alarm
        logic       enc_mode;      // 1: encoded state, 0: proportional
        logic       bin_idle_high; // binary output idles high
        logic       bin_latch;     // alarm outputs latch until power off
        logic       fet_idle_on;   // power switch idles on
        logic       err_as_alarm;  // errors force alarm instead of error
    } gas_cfg_t;

    typedef struct packed {
        logic sensor_fail;
        logic temp_bad;
    } gas_fault_t;

    typedef struct packed {
        logic fw_bad;
        logic cal_bad;
        logic cfg_bad;
    } gas_cksum_t;

    // timing, in ms as printed, and derived cycle counts at 200 MHz
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned WARMUP_MS = 2000;
    localparam int unsigned BLINK_MS = 500;
    localparam int unsigned ERR_PERIOD_MS = 10000;
    localparam int unsigned ERR_PULSE_MS = 100;
    localparam int unsigned DEBOUNCE_MS = 100;
    localparam int unsigned WARMUP_CYC = WARMUP_MS * CYC_PER_MS;
    localparam int unsigned BLINK_CYC = BLINK_MS * CYC_PER_MS;
    localparam int unsigned ERR_PERIOD_CYC = ERR_PERIOD_MS * CYC_PER_MS;
    localparam int unsigned ERR_PULSE_CYC = ERR_PULSE_MS * CYC_PER_MS;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
    localparam int unsigned CNT_W = 32;

    // output coding
    localparam logic [10:0] DAC_OFFSET = 11'h0aa;
    localparam logic [9:0] DAC_MAX = 10'h3ff;
    localparam logic [7:0] CONC_FULL = 8'hff;
    localparam logic [9:0] LVL_FAULT_LO = 10'h000;
    localparam logic [9:0] LVL_NORMAL = 10'h0ab;
    localparam logic [9:0] LVL_WARNING = 10'h1aa;
    localparam logic [9:0] LVL_ALARM = 10'h2aa;
    localparam logic [9:0] LVL_FAULT_HI = 10'h3aa;
    localparam logic [15:0] PCT_DIV = 16'h0064;

    // four codes per reading step above the safety offset
    function automatic logic [9:0] dac_code(input logic [7:0] conc);
        logic [10:0] sum;
        sum = DAC_OFFSET + {1'b0, conc, 2'b00};
        return sum[10] ? DAC_MAX : sum[9:0];
    endfunction

    function automatic logic [9:0] enc_level(input gas_state_t st);
        logic [9:0] lvl;
        unique case (st)
            ST_WARMUP: lvl = LVL_FAULT_LO;
            ST_NORMAL: lvl = LVL_NORMAL;
            ST_WARNING: lvl = LVL_WARNING;
            ST_ALARM: lvl = LVL_ALARM;
            ST_ERROR: lvl = LVL_FAULT_HI;
        endcase
        return lvl;
    endfunction

    // warning level as a percentage of the alarm level, saturated
    function automatic logic [7:0] warn_level(input logic [7:0] thr,
                                              input logic [7:0] pct);
        logic [15:0] q;
        q = (thr * pct) / PCT_DIV;
        return (q[15:8] != 8'h00) ? 8'hff : q[7:0];
    endfunction
endpackage

// ----------------------------------------------------------------------
// debouncer: output follows input only after it held for HOLD_CYC
// ----------------------------------------------------------------------
module gas_debounce #(
    parameter int unsigned HOLD_CYC = gas_pkg::DEBOUNCE_CYC
) (
    input wire logic clk_in,  // core clock
    input wire logic rstn_in, // async reset, active low
    input wire logic raw_in,  // undebounced level
    output logic stable_out   // debounced level
);
    import gas_pkg::*;

    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= '0;
            stable_out <= 1'b0;
        end else if (raw_in == stable_out) begin
            cnt_q <= '0;
        end else if (cnt_q >= HOLD_CYC - 1) begin
            cnt_q <= '0;
            stable_out <= raw_in;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// ==== verilog/gas_state_ctrl.sv ====
// state controller and output encoder of the gas alarm monitor
// Operation
// - enter alarm when reading reaches or exceeds the configured alarm level
// - enter warning at a configured percentage of the alarm level
// - warning: indicator alternates red and green
// - alarm: indicator alternates red and dark
// - error on sensor failure, temperature out of range or bad checksum
// - error: report full-scale reading in place of the measurement
// - error: indicator dark with a short red pulse about every ten seconds
// - sensor and temperature errors clear by themselves when the cause goes
// - low voltage or watchdog timeout restarts in warm-up, not error
// - proportional code steps four units per reading step
// - proportional code carries a fixed offset of 170 steps
// - encoded mode: one level per normal, warning and alarm state
// - encoded mode: faults at the bottom or top level
// - binary alarm output asserts on alarm, idle polarity configurable
// - alarm output auto-releases or latches until power is cycled
// - power switch asserts on alarm, idle on or off configurable
// - errors reported as error state or forced alarm, by configuration
// - checksum failure after power-up holds the error state
// - baseline capture refused at high concentration, baseline unchanged
// - readings averaged and threshold crossings debounced
// - after reset: two seconds warm-up, zero reading, green blink
// - normal: steady green; other states fall back to normal
`timescale 1ns/1ps

module gas_state_ctrl #(
    parameter int unsigned WARMUP_CYC_P = gas_pkg::WARMUP_CYC,
    parameter int unsigned BLINK_CYC_P = gas_pkg::BLINK_CYC,
    parameter int unsigned ERR_PERIOD_CYC_P = gas_pkg::ERR_PERIOD_CYC,
    parameter int unsigned ERR_PULSE_CYC_P = gas_pkg::ERR_PULSE_CYC,
    parameter int unsigned DEBOUNCE_CYC_P = gas_pkg::DEBOUNCE_CYC
) (
    input wire logic CORE_CLK_IN,                // 200 MHz core clock
    input wire logic RSTN_IN,                    // power-on reset, low
    input wire gas_pkg::gas_cfg_t CFG_IN,        // stored configuration
    input wire gas_pkg::gas_fault_t FAULT_IN,    // live fault levels
    input wire logic CKSUM_DONE_IN,              // checksum result strobe
    input wire gas_pkg::gas_cksum_t CKSUM_FAIL_IN, // failed memories
    input wire logic WATCHDOG_TIMEOUT_RESET_IN,  // watchdog timeout
    input wire logic LOW_VOLT_INHIBIT_IN,        // supply below limit
    input wire logic SAMPLE_VALID_IN,            // new raw sample strobe
    input wire logic [7:0] RAW_LEVEL_IN,         // scaled raw reading
    input wire logic ZERO_REQ_IN,                // baseline capture request
    output gas_pkg::gas_state_t STATE_OUT,       // device state
    output logic [7:0] CONC_OUT,                 // reported reading
    output logic [9:0] DAC_CODE_OUT,             // output converter code
    output logic LED_RED_OUT,                    // red indicator
    output logic LED_GREEN_OUT,                  // green indicator
    output logic BIN_ALARM_OUT,                  // binary alarm level
    output logic FET_GATE_OUT,                   // power switch gate
    output logic [7:0] BASELINE_OUT,             // stored baseline
    output logic ZERO_DONE_OUT,                  // capture accepted pulse
    output logic ZERO_REJECT_OUT                 // capture refused pulse
);
    import gas_pkg::*;

    gas_state_t state_q;
    gas_state_t state_d;
    logic [CNT_W-1:0] wu_cnt_q;
    logic [CNT_W-1:0] blink_cnt_q;
    logic [CNT_W-1:0] err_cnt_q;
    logic blink_q;
    logic cksum_bad_q;
    logic latch_q;
    logic [9:0] acc_q;
    logic [7:0] baseline_q;
    logic [7:0] net_w;
    logic [7:0] avg_w;
    logic [7:0] warn_lvl_w;
    logic [7:0] reading_w;
    logic restart_w;
    logic err_now_w;
    logic wu_done_w;
    logic alarm_db_w;
    logic warn_db_w;
    logic high_conc_w;
    logic bin_act_w;

    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    // ------------------------------------------------------------------
    // reading path: baseline, averaging, thresholds
    // ------------------------------------------------------------------
    assign net_w = (RAW_LEVEL_IN > baseline_q) ?
                   8'(RAW_LEVEL_IN - baseline_q) : 8'h00;
    assign avg_w = acc_q[9:2];
    assign warn_lvl_w = warn_level(CFG_IN.alarm_thr, CFG_IN.warn_pct);
    // "high" taken as at or above the warning level
    assign high_conc_w = avg_w >= warn_lvl_w;

    // accumulator holds four times the average, so a steady input
    // settles on its exact value without rounding drift
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            acc_q <= '0;
        end else if (SAMPLE_VALID_IN) begin
            acc_q <= acc_q - {2'b00, acc_q[9:2]} + {2'b00, net_w};
        end
    end

    gas_debounce #(
        .HOLD_CYC(DEBOUNCE_CYC_P)
    ) u_alarm_db (
        .clk_in(CORE_CLK_IN),
        .rstn_in(RSTN_IN),
        .raw_in(avg_w >= CFG_IN.alarm_thr),
        .stable_out(alarm_db_w)
    );

    gas_debounce #(
        .HOLD_CYC(DEBOUNCE_CYC_P)
    ) u_warn_db (
        .clk_in(CORE_CLK_IN),
        .rstn_in(RSTN_IN),
        .raw_in(avg_w >= warn_lvl_w),
        .stable_out(warn_db_w)
    );

    // ------------------------------------------------------------------
    // baseline capture
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            baseline_q <= '0;
            ZERO_DONE_OUT <= 1'b0;
            ZERO_REJECT_OUT <= 1'b0;
        end else begin
            ZERO_DONE_OUT <= ZERO_REQ_IN && !high_conc_w;
            ZERO_REJECT_OUT <= ZERO_REQ_IN && high_conc_w;
            if (ZERO_REQ_IN && !high_conc_w) begin
                baseline_q <= RAW_LEVEL_IN;
            end
        end
    end
    assign BASELINE_OUT = baseline_q;

    a_zero_reject: assert property (
        ZERO_REQ_IN && high_conc_w |=> ZERO_REJECT_OUT && $stable(baseline_q))
        else $error("baseline captured at high concentration");

    // ------------------------------------------------------------------
    // error sources
    // ------------------------------------------------------------------
    // checksums are judged once per power-up; only a full reset clears
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cksum_bad_q <= 1'b0;
        end else if (CKSUM_DONE_IN && (|CKSUM_FAIL_IN)) begin
            cksum_bad_q <= 1'b1;
        end
    end

    // sensor and temperature are live levels, so those errors end with their cause; the checksum flag holds
    assign err_now_w = FAULT_IN.sensor_fail || FAULT_IN.temp_bad ||
                       cksum_bad_q;
    assign restart_w = WATCHDOG_TIMEOUT_RESET_IN || LOW_VOLT_INHIBIT_IN;

    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    assign wu_done_w = wu_cnt_q >= WARMUP_CYC_P - 1;

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            wu_cnt_q <= '0;
        end else if (restart_w || state_q != ST_WARMUP) begin
            wu_cnt_q <= '0;
        end else if (!wu_done_w) begin
            wu_cnt_q <= wu_cnt_q + 1'b1;
        end
    end

    always_comb begin
        state_d = state_q;
        if (restart_w) begin
            state_d = ST_WARMUP;
        end else if (state_q == ST_WARMUP) begin
            if (wu_done_w) begin
                state_d = ST_NORMAL;
            end
        end else if (err_now_w) begin
            state_d = CFG_IN.err_as_alarm ? ST_ALARM : ST_ERROR;
        end else if (alarm_db_w) begin
            state_d = ST_ALARM;
        end else if (warn_db_w) begin
            state_d = ST_WARNING;
        end else begin
            state_d = ST_NORMAL;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_q <= ST_WARMUP;
        end else begin
            state_q <= state_d;
        end
    end
    assign STATE_OUT = state_q;

    a_restart_warm: assert property (
        restart_w |=> state_q == ST_WARMUP ##1 !LED_RED_OUT)
        else $error("restart did not return to warm-up");

    a_error_prio: assert property (
        state_q != ST_WARMUP && !restart_w && err_now_w &&
        !CFG_IN.err_as_alarm |=> state_q == ST_ERROR)
        else $error("error condition did not win");

    a_err_forced: assert property (
        state_q != ST_WARMUP && !restart_w && err_now_w &&
        CFG_IN.err_as_alarm |=> state_q == ST_ALARM)
        else $error("error not reported as alarm");

    a_err_clears: assert property (
        state_q == ST_ERROR && !restart_w && !err_now_w && !alarm_db_w &&
        !warn_db_w |=> state_q == ST_NORMAL)
        else $error("error did not clear with its cause");

    a_cksum_hold: assert property (
        cksum_bad_q && state_q != ST_WARMUP && !CFG_IN.err_as_alarm &&
        !restart_w |=> state_q == ST_ERROR ##1 cksum_bad_q)
        else $error("checksum failure left the error state");

    // ------------------------------------------------------------------
    // reported reading and converter code
    // ------------------------------------------------------------------
    always_comb begin
        unique case (state_q)
            ST_WARMUP: reading_w = 8'h00;
            ST_ERROR: reading_w = CONC_FULL;
            // a forced alarm from an error still fails safe
            default: reading_w = err_now_w ? CONC_FULL : avg_w;
        endcase
    end

    // reset code sits on the offset so a live zero is never mistaken
    // for a broken wire
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            CONC_OUT <= '0;
            DAC_CODE_OUT <= DAC_OFFSET[9:0];
        end else begin
            CONC_OUT <= reading_w;
            if (CFG_IN.enc_mode) begin
                DAC_CODE_OUT <= enc_level(state_q);
            end else begin
                DAC_CODE_OUT <= dac_code(reading_w);
            end
        end
    end

    a_err_full: assert property (
        state_q == ST_ERROR |=> CONC_OUT == CONC_FULL)
        else $error("error state reading not full scale");

    a_warmup_zero: assert property (
        state_q == ST_WARMUP |=> CONC_OUT == 8'h00)
        else $error("warm-up reading not zero");

    a_dac_prop: assert property (
        !CFG_IN.enc_mode |=> DAC_CODE_OUT == dac_code(CONC_OUT))
        else $error("proportional code wrong");

    a_enc_level: assert property (
        CFG_IN.enc_mode |=> DAC_CODE_OUT == enc_level($past(state_q)))
        else $error("encoded level wrong");

    // ------------------------------------------------------------------
    // indicator timing
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end else if (blink_cnt_q >= BLINK_CYC_P - 1) begin
            blink_cnt_q <= '0;
            blink_q <= !blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
        end
    end

    // restarted on entry so the first red pulse comes at once
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            err_cnt_q <= '0;
        end else if (state_q != ST_ERROR ||
                     err_cnt_q >= ERR_PERIOD_CYC_P - 1) begin
            err_cnt_q <= '0;
        end else begin
            err_cnt_q <= err_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            LED_RED_OUT <= 1'b0;
            LED_GREEN_OUT <= 1'b0;
        end else begin
            unique case (state_q)
                ST_WARMUP: begin
                    LED_RED_OUT <= 1'b0;
                    LED_GREEN_OUT <= blink_q;
                end
                ST_NORMAL: begin
                    LED_RED_OUT <= 1'b0;
                    LED_GREEN_OUT <= 1'b1;
                end
                ST_WARNING: begin
                    LED_RED_OUT <= blink_q;
                    LED_GREEN_OUT <= !blink_q;
                end
                ST_ALARM: begin
                    LED_RED_OUT <= blink_q;
                    LED_GREEN_OUT <= 1'b0;
                end
                ST_ERROR: begin
                    LED_RED_OUT <= err_cnt_q < ERR_PULSE_CYC_P;
                    LED_GREEN_OUT <= 1'b0;
                end
            endcase
        end
    end

    a_warn_led: assert property (
        state_q == ST_WARNING |=> LED_RED_OUT != LED_GREEN_OUT)
        else $error("warning indicator not red/green");

    a_alarm_led: assert property (
        state_q == ST_ALARM |=> !LED_GREEN_OUT)
        else $error("alarm indicator shows green");

    a_error_led: assert property (
        state_q == ST_ERROR && err_cnt_q >= ERR_PULSE_CYC_P
        |=> !LED_RED_OUT && !LED_GREEN_OUT)
        else $error("error indicator lit outside its pulse");

    a_normal_green: assert property (
        state_q == ST_NORMAL |=> LED_GREEN_OUT && !LED_RED_OUT)
        else $error("normal indicator not steady green");

    // ------------------------------------------------------------------
    // binary alarm and power switch
    // ------------------------------------------------------------------
    // the latch survives watchdog and low-voltage restarts; only a
    // power-on reset clears it
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            latch_q <= 1'b0;
        end else if (state_q == ST_ALARM && CFG_IN.bin_latch) begin
            latch_q <= 1'b1;
        end
    end

    assign bin_act_w = (state_q == ST_ALARM) || latch_q;

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            BIN_ALARM_OUT <= 1'b0;
            FET_GATE_OUT <= 1'b0;
        end else begin
            BIN_ALARM_OUT <= bin_act_w ^ CFG_IN.bin_idle_high;
            FET_GATE_OUT <= bin_act_w ^ CFG_IN.fet_idle_on;
        end
    end

    a_bin_alarm: assert property (
        state_q == ST_ALARM |=> BIN_ALARM_OUT != $past(CFG_IN.bin_idle_high))
        else $error("binary alarm not active in alarm");

    a_fet_alarm: assert property (
        state_q == ST_ALARM |=> FET_GATE_OUT != $past(CFG_IN.fet_idle_on))
        else $error("power switch not active in alarm");

    a_latch_hold: assert property (
        latch_q |=> latch_q ##1 bin_act_w)
        else $error("latched alarm released");

    // ------------------------------------------------------------------
    // main scenarios
    // ------------------------------------------------------------------
    c_alarm: cover property (state_q == ST_WARNING ##1 state_q == ST_ALARM);
    c_error: cover property (state_q == ST_ERROR ##1 state_q == ST_NORMAL);
    c_reject: cover property (ZERO_REJECT_OUT);
    c_latched: cover property (latch_q && state_q == ST_NORMAL);
endmodule

// ==== tb/gas_panel_model.sv ====
// alarm panel model that reads the controller's output lines
`timescale 1ns/1ps

module gas_panel_model (
    input wire logic clk_in,        // panel sampling clock
    input wire logic [9:0] dac_in,  // converter code on the line
    input wire logic bin_in,        // binary alarm line
    input wire logic idle_high_in,  // panel wired for idle-high line
    input wire logic fet_in,        // power switch gate
    input wire logic fet_idle_in,   // panel wired for switch idle on
    output logic alarm_out,         // binary line reads as alarm
    output logic fet_alarm_out,     // switch reads as alarm
    output logic trouble_out        // offset missing on the line
);
    // sampled like a real panel, so it lags the lines by one cycle
    always_ff @(posedge clk_in) begin
        alarm_out <= bin_in ^ idle_high_in;
        fet_alarm_out <= fet_in ^ fet_idle_in;
        trouble_out <= (dac_in < 10'h0aa);
    end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the gas alarm state controller
`timescale 1ns/1ps

module testbench;
    import gas_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    gas_cfg_t cfg = '{8'hc8, 8'h32, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    gas_fault_t flt = '0;
    gas_cksum_t ck = '0;
    logic ck_done = 1'b0;
    logic wd = 1'b0;
    logic lvi = 1'b0;
    logic sv = 1'b0;
    logic zreq = 1'b0;
    logic [7:0] raw = 8'h00;
    gas_state_t st;
    logic [7:0] conc, base;
    logic [9:0] dac;
    logic red, grn, bin, fet, zdone, zrej, p_alarm, p_fet, p_trouble;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    gas_state_ctrl #(.WARMUP_CYC_P(40), .BLINK_CYC_P(4),
        .ERR_PERIOD_CYC_P(40), .ERR_PULSE_CYC_P(3), .DEBOUNCE_CYC_P(3))
    i_gas_state_ctrl (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CFG_IN(cfg),
        .FAULT_IN(flt), .CKSUM_DONE_IN(ck_done), .CKSUM_FAIL_IN(ck),
        .WATCHDOG_TIMEOUT_RESET_IN(wd), .LOW_VOLT_INHIBIT_IN(lvi),
        .SAMPLE_VALID_IN(sv), .RAW_LEVEL_IN(raw), .ZERO_REQ_IN(zreq),
        .STATE_OUT(st), .CONC_OUT(conc), .DAC_CODE_OUT(dac),
        .LED_RED_OUT(red), .LED_GREEN_OUT(grn), .BIN_ALARM_OUT(bin),
        .FET_GATE_OUT(fet), .BASELINE_OUT(base), .ZERO_DONE_OUT(zdone),
        .ZERO_REJECT_OUT(zrej));
    gas_panel_model i_gas_panel_model (.clk_in(clk), .dac_in(dac),
        .bin_in(bin), .idle_high_in(cfg.bin_idle_high), .fet_in(fet),
        .fet_idle_in(cfg.fet_idle_on), .alarm_out(p_alarm),
        .fet_alarm_out(p_fet), .trouble_out(p_trouble));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // long enough for the average to settle on the net reading
    task automatic feed(input logic [7:0] r);
        raw = r;
        sv = 1'b1;
        tick(60);
        sv = 1'b0;
        tick(8);
    endtask
    // answer pulses stand one cycle, so they are taken right after it
    task automatic zero(input logic [7:0] r, output logic [9:0] res);
        raw = r;
        zreq = 1'b1;
        tick(1);
        res = {zrej, zdone, base};
        zreq = 1'b0;
        tick(1);
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            stop_test();
        end
    end
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_levels;
        logic [9:0] zr;
        feed(8'd20);
        chk(st, ST_NORMAL);
        chk(dac, 10'h0fa);
        chk({p_trouble, bin, fet}, 10'h002);
        feed(8'd120);
        chk(st, ST_WARNING);
        chk(red ^ grn, 10'h001);
        feed(8'd200);
        chk(st, ST_ALARM);
        chk({grn, p_alarm, p_fet}, 10'h003);
        zero(8'd9, zr);
        chk(zr, {2'b10, 8'h00});
        feed(8'd20);
        chk({st, bin}, {ST_NORMAL, 1'b1});
    endtask
    task automatic t_errors;
        flt.sensor_fail = 1'b1;
        tick(3);
        chk(st, ST_ERROR);
        chk({red, grn, conc}, {2'b10, CONC_FULL});
        flt.sensor_fail = 1'b0;
        tick(3);
        chk(st, ST_NORMAL);
        cfg.err_as_alarm = 1'b1;
        flt.temp_bad = 1'b1;
        tick(3);
        chk({st, conc}, {ST_ALARM, CONC_FULL});
        cfg.err_as_alarm = 1'b0;
        cfg.enc_mode = 1'b1;
        tick(3);
        chk(dac, LVL_FAULT_HI);
        flt.temp_bad = 1'b0;
        tick(3);
        chk(dac, LVL_NORMAL);
        cfg.enc_mode = 1'b0;
    endtask
    task automatic t_restart;
        logic [9:0] zr;
        wd = 1'b1;
        tick(1);
        wd = 1'b0;
        lvi = 1'b1;
        tick(60);
        chk({st, conc}, {ST_WARMUP, 8'h00});
        cfg.enc_mode = 1'b1;
        tick(2);
        chk({p_trouble, dac}, {1'b1, LVL_FAULT_LO});
        cfg.enc_mode = 1'b0;
        lvi = 1'b0;
        tick(45);
        chk(st, ST_NORMAL);
        zero(8'd5, zr);
        chk(zr, {2'b01, 8'h05});
    endtask
    task automatic t_memory;
        cfg.bin_latch = 1'b1;
        feed(8'd250);
        feed(8'd5);
        chk({st, bin}, {ST_NORMAL, 1'b0});
        ck = '{1'b0, 1'b1, 1'b0};
        ck_done = 1'b1;
        tick(1);
        ck_done = 1'b0;
        wd = 1'b1;
        tick(1);
        wd = 1'b0;
        tick(45);
        chk(st, ST_ERROR);
        rstn = 1'b0;
        tick(1);
        chk({dac, bin}, {10'h0aa, 1'b0});
        rstn = 1'b1;
        tick(45);
        chk({st, bin}, {ST_NORMAL, 1'b1});
    endtask
    initial begin
        tick(5);
        chk(dac, 10'h0aa);
        rstn = 1'b1;
        tick(1);
        chk({st, grn}, {ST_WARMUP, 1'b0});
        tick(45);
        chk({st, grn, red}, {ST_NORMAL, 2'b10});
        t_levels();
        t_errors();
        t_restart();
        t_memory();
        stop_test();
    end
endmodule
